// ===== core/pmm_defs.svh
`ifndef PMM_DEFS_SVH
`define PMM_DEFS_SVH

`define PMM_OFS_CTRL 8'h00
`define PMM_OFS_STAT 8'h04
`define PMM_GRP_RES 4'h1
`define PMM_GRP_MIN 4'h2
`define PMM_GRP_MAX 4'h3
`define PMM_GRP_THMAX 4'h4
`define PMM_GRP_THMIN 4'h5

`define PMM_CTRL_SS 7
`define PMM_CTRL_CH_HI 6
`define PMM_CTRL_CH_LO 5
`define PMM_CTRL_BUSY 3
`define PMM_CTRL_SRC_HI 2
`define PMM_CTRL_SHDN 1
`define PMM_CTRL_SRC_LO 0
`define PMM_CTRL_RST 8'h05

`define PMM_Q_CUR 2'h0
`define PMM_Q_VOLT 2'h1
`define PMM_Q_AUX 2'h2
`define PMM_Q_PWR 2'h3

`define PMM_CH_CUR 2'h0
`define PMM_CH_VDD 2'h1
`define PMM_CH_SENSE 2'h2
`define PMM_CH_AUX 2'h3

`define PMM_ALL_ONES 24'hffffff
`define PMM_ALL_ZERO 24'h000000
`define PMM_RES_RST 24'h000000

`endif

// ===== core/pmm_monitor.sv
// Behaviour
// (RULE1) Serial logic and converter enable once either supply passes its lockout level.
// (RULE2) Converter turns off only when both supplies fall below lockout.
// (RULE3) Serial logic resets when both supplies drop below interface-reset level.
// (RULE4) Shutdown bit powers down converter and reference; no conversions.
// (RULE5) In shutdown address pins ignored, last bus address kept.
// (RULE6) Shutdown entry or exit keeps all registers, still accessible.
// (RULE7) Clearing shutdown resumes conversions with registers preserved.
// (RULE8) Regulator enable low during shutdown, high again afterwards.
// (RULE9) Host avoids shutdown when regulator powers bus circuitry.
// (RULE10) Two source bits pick sense, supply pin or auxiliary voltage.
// (RULE11) Power is 12-bit current times selected 12-bit voltage, 24 bits.
// (RULE12) Power kept in three bytes, refreshed once per scan cycle.
// (RULE13) Single-shot mode leaves power registers unchanged.
// (RULE14) Each new value replaces stored min if lower, max if higher.
// (RULE15) Extremes update at end of each conversion, both modes.
// (RULE16) Bus write of a result beyond an extreme updates that extreme.
// (RULE17) Host restarts peak tracking with min all ones, max zeros.
// (RULE18) Max thresholds reset to all ones, min thresholds to zeros.
// (RULE19) Thresholds accept any written value.
// (RULE20) Measurements read left-justified, lowest nibble zero.
// (RULE21) Scan order current, selected supply voltage, auxiliary, repeating.
// (RULE22) Single shot by control bit plus channel code; busy flag meanwhile.
// (RULE23) Comparisons unsigned, 12 bits for measurements, 24 for power.
// (RULE24) Power uses current and voltage of the same completed scan.
//
// Chosen here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ns
`include "pmm_defs.svh"

module pmm_monitor (
    input wire logic core_clk,
    input wire logic rst,
    input wire pmm_pkg::pmm_wb_req_t wbReq,
    output logic wbAck,
    output logic [31:0] wbDat,
    input wire logic vddAboveUvlo,
    input wire logic lowSupplyAboveUvlo,
    input wire logic vddAboveLogicRst,
    input wire logic lowSupplyAboveLogicRst,
    input wire logic [1:0] addr_select_pin_hi,
    input wire logic [1:0] addr_select_pin_lo,
    input wire pmm_pkg::pmm_adc_res_t adcRes,
    output logic adcEnable,
    output logic refEnable,
    output logic adcStart,
    output logic [1:0] adcChanSel,
    output logic regulatorEnable,
    output logic serialEnable,
    output logic [3:0] busAddr
);
    import pmm_pkg::*;

    pmm_state_t state_q;
    pmm_state_t state_d;

    logic uvloOk;
    logic logicOk;
    logic shutdown;
    logic single;
    logic [1:0] qty;
    logic [23:0] value;
    logic [23:0] volt;
    logic [23:0] product;
    logic busReq;
    logic [3:0] grp;
    logic [1:0] bq;
    logic [31:0] rdVal;
    logic ctrlHit;
    logic statHit;
    logic [23:0] curWide;
    logic [23:0] voltWide;

    function automatic pmm_regs_t regsReset();
        pmm_regs_t r;
        r.ctrl = `PMM_CTRL_RST;
        for (int i = 0; i < 4; i++) begin
            r.res[i] = `PMM_RES_RST;
            r.minv[i] = `PMM_ALL_ONES;
            r.maxv[i] = `PMM_ALL_ZERO;
            r.thMax[i] = `PMM_ALL_ONES; // [RULE18]
            r.thMin[i] = `PMM_ALL_ZERO; // [RULE18]
        end
        return r;
    endfunction

    // Width of a quantity: power is 24 bits, the rest 12
    function automatic logic [23:0] widthMask(input logic [1:0] q, input logic [23:0] v);
        return (q == `PMM_Q_PWR) ? v : {12'h000, v[11:0]}; // [RULE23]
    endfunction

    function automatic logic [31:0] toBus(input logic [1:0] q, input logic [23:0] v);
        if (q == `PMM_Q_PWR) begin
            return {8'h00, v}; // [RULE12]
        end
        return {16'h0000, v[11:0], 4'h0}; // [RULE20]
    endfunction

    function automatic logic [23:0] fromBus(input logic [1:0] q, input logic [31:0] d);
        if (q == `PMM_Q_PWR) begin
            return d[23:0];
        end
        return {12'h000, d[15:4]}; // [RULE20]
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
        logic [31:0] r;
        for (int i = 0; i < 4; i++) begin
            r[i*8 +: 8] = sel[i] ? d[i*8 +: 8] : old[i*8 +: 8];
        end
        return r;
    endfunction

    // Store a value and fold it into the extremes
    function automatic pmm_regs_t storeValue(input pmm_regs_t r, input logic [1:0] q,
                                             input logic [23:0] v);
        pmm_regs_t o;
        o = r;
        o.res[q] = widthMask(q, v);
        if (widthMask(q, v) < widthMask(q, r.minv[q])) begin
            o.minv[q] = widthMask(q, v); // [RULE14] [RULE23]
        end
        if (widthMask(q, v) > widthMask(q, r.maxv[q])) begin
            o.maxv[q] = widthMask(q, v); // [RULE14] [RULE23]
        end
        return o;
    endfunction

    // Converter channel to result slot; both supply channels share the voltage slot
    function automatic logic [1:0] chanQty(input logic [1:0] ch);
        unique case (ch)
            `PMM_CH_CUR: return `PMM_Q_CUR;
            `PMM_CH_VDD: return `PMM_Q_VOLT;
            `PMM_CH_SENSE: return `PMM_Q_VOLT;
            `PMM_CH_AUX: return `PMM_Q_AUX;
        endcase
    endfunction

    always_comb begin
        state_d = state_q;
        // First stage feeds only the second
        state_d.pinsSync1 = {addr_select_pin_hi, addr_select_pin_lo, lowSupplyAboveLogicRst,
                             vddAboveLogicRst, lowSupplyAboveUvlo, vddAboveUvlo};
        state_d.pinsSync2 = state_q.pinsSync1;
        uvloOk = state_q.pinsSync2[0] | state_q.pinsSync2[1];
        logicOk = state_q.pinsSync2[2] | state_q.pinsSync2[3];
        shutdown = state_q.regs.ctrl[`PMM_CTRL_SHDN];
        single = state_q.regs.ctrl[`PMM_CTRL_SS];

        if (uvloOk) begin
            state_d.serialEnable = 1'b1; // [RULE1]
        end else if (!logicOk) begin
            state_d.serialEnable = 1'b0; // [RULE3]
        end
        // Apart from shutdown, both low is the only way off, so either supply keeps it alive
        state_d.adcEnable = uvloOk & ~shutdown; // [RULE1] [RULE2] [RULE4] [RULE7]
        state_d.refEnable = ~shutdown; // [RULE4] [RULE7]
        state_d.regulatorEnable = ~shutdown; // [RULE8]
        if (!shutdown) begin
            state_d.busAddr = state_q.pinsSync2[7:4]; // [RULE5]
        end

        // Sequencer
        qty = chanQty(state_q.convChan);
        value = {12'h000, adcRes.data};
        // Aux arrives last in the scan, so take it fresh rather than the stored copy
        volt = (state_q.regs.ctrl[`PMM_CTRL_SRC_HI] && !state_q.regs.ctrl[`PMM_CTRL_SRC_LO])
            ? value : state_q.regs.res[`PMM_Q_VOLT]; // [RULE10] [RULE24]
        curWide = {12'h000, state_q.regs.res[`PMM_Q_CUR][11:0]};
        voltWide = {12'h000, volt[11:0]};
        product = curWide * voltWide; // [RULE11]
        state_d.adcStart = 1'b0;
        unique case (state_q.seq)
            PMM_IDLE: begin
                if (state_q.adcEnable && single) begin
                    if (state_q.regs.ctrl[`PMM_CTRL_BUSY]) begin
                        state_d.convChan = state_q.regs.ctrl[`PMM_CTRL_CH_HI:`PMM_CTRL_CH_LO];
                        state_d.ssConv = 1'b1;
                        state_d.adcStart = 1'b1; // [RULE22]
                        state_d.seq = PMM_CONV;
                    end
                end else if (state_q.adcEnable) begin
                    unique case (state_q.step)
                        2'd0: state_d.convChan = `PMM_CH_CUR; // [RULE21]
                        2'd1: state_d.convChan = state_q.regs.ctrl[`PMM_CTRL_SRC_HI]
                            ? `PMM_CH_SENSE : `PMM_CH_VDD; // [RULE21] [RULE10]
                        default: state_d.convChan = `PMM_CH_AUX; // [RULE21]
                    endcase
                    state_d.ssConv = 1'b0;
                    state_d.adcStart = 1'b1;
                    state_d.seq = PMM_CONV;
                end
            end
            PMM_CONV: begin
                if (!state_q.adcEnable) begin
                    // Shutdown aborts the conversion in flight; result registers untouched
                    state_d.seq = PMM_IDLE; // [RULE4] [RULE6]
                    state_d.step = 2'd0;
                    state_d.regs.ctrl[`PMM_CTRL_BUSY] = 1'b0;
                end else if (adcRes.done) begin
                    state_d.regs = storeValue(state_q.regs, qty, value); // [RULE15]
                    state_d.seq = PMM_IDLE;
                    if (state_q.ssConv) begin
                        state_d.regs.ctrl[`PMM_CTRL_BUSY] = 1'b0; // [RULE22] [RULE13]
                    end else if (state_q.step == 2'd2) begin
                        // Current and voltage both from this scan
                        state_d.regs = storeValue(state_d.regs, `PMM_Q_PWR,
                                                  product); // [RULE12] [RULE24] [RULE14]
                        state_d.step = 2'd0;
                    end else begin
                        state_d.step = state_q.step + 2'd1;
                    end
                end
            end
        endcase
        state_d.adcChanSel = state_d.convChan;

        // Wishbone slave, one wait state, answers every address
        busReq = wbReq.cyc & wbReq.stb & ~state_q.wbAck;
        grp = wbReq.adr[7:4];
        bq = wbReq.adr[3:2];
        ctrlHit = ({wbReq.adr[7:2], 2'b00} == `PMM_OFS_CTRL);
        statHit = ({wbReq.adr[7:2], 2'b00} == `PMM_OFS_STAT);
        state_d.wbAck = busReq;
        rdVal = 32'h0000_0000;
        if (ctrlHit) begin
            rdVal = {24'h000000, state_q.regs.ctrl};
        end else if (statHit) begin
            rdVal = {24'h000000, state_q.busAddr, state_q.regulatorEnable,
                     state_q.refEnable, state_q.adcEnable, state_q.serialEnable};
        end else begin
            unique case (grp)
                `PMM_GRP_RES: rdVal = toBus(bq, state_q.regs.res[bq]);
                `PMM_GRP_MIN: rdVal = toBus(bq, state_q.regs.minv[bq]);
                `PMM_GRP_MAX: rdVal = toBus(bq, state_q.regs.maxv[bq]);
                `PMM_GRP_THMAX: rdVal = toBus(bq, state_q.regs.thMax[bq]);
                `PMM_GRP_THMIN: rdVal = toBus(bq, state_q.regs.thMin[bq]);
                default: rdVal = 32'h0000_0000;
            endcase
        end
        state_d.wbDat = busReq ? rdVal : 32'h0000_0000;

        // Bus writes land after the sequencer so a busy set wins over the done clear
        if (busReq && wbReq.we) begin // [RULE6]
            if (ctrlHit) begin
                state_d.regs.ctrl = 8'(merge({24'h000000, state_d.regs.ctrl}, wbReq.dat,
                                             wbReq.sel));
                // Busy is read-only; a write with single shot set starts one
                state_d.regs.ctrl[`PMM_CTRL_BUSY] = state_d.regs.ctrl[`PMM_CTRL_SS]
                    & wbReq.sel[0] ? 1'b1 : state_q.regs.ctrl[`PMM_CTRL_BUSY]; // [RULE22]
                if (!(wbReq.sel[0] && wbReq.dat[`PMM_CTRL_SS])) begin
                    state_d.regs.ctrl[`PMM_CTRL_BUSY] = state_d.regs.ctrl[`PMM_CTRL_BUSY]
                        & state_q.regs.ctrl[`PMM_CTRL_SS] & wbReq.dat[`PMM_CTRL_SS];
                end
            end else begin
                unique case (grp)
                    `PMM_GRP_RES: state_d.regs = storeValue(state_d.regs, bq,
                        fromBus(bq, merge(toBus(bq, state_d.regs.res[bq]), wbReq.dat,
                                          wbReq.sel))); // [RULE16]
                    `PMM_GRP_MIN: state_d.regs.minv[bq] = fromBus(bq,
                        merge(toBus(bq, state_d.regs.minv[bq]), wbReq.dat, wbReq.sel));
                    `PMM_GRP_MAX: state_d.regs.maxv[bq] = fromBus(bq,
                        merge(toBus(bq, state_d.regs.maxv[bq]), wbReq.dat, wbReq.sel));
                    `PMM_GRP_THMAX: state_d.regs.thMax[bq] = fromBus(bq,
                        merge(toBus(bq, state_d.regs.thMax[bq]), wbReq.dat,
                              wbReq.sel)); // [RULE19]
                    `PMM_GRP_THMIN: state_d.regs.thMin[bq] = fromBus(bq,
                        merge(toBus(bq, state_d.regs.thMin[bq]), wbReq.dat,
                              wbReq.sel)); // [RULE19]
                    // Status and unmapped words are acked and the write dropped
                    default: state_d.regs = state_d.regs;
                endcase
            end
        end

        // Logic reset only when both supplies have collapsed
        if (!logicOk) begin
            state_d.regs = regsReset(); // [RULE3]
            state_d.seq = PMM_IDLE;
            state_d.step = 2'd0;
            state_d.adcStart = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= '0;
            state_q.regs <= regsReset();
            state_q.seq <= PMM_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign wbAck = state_q.wbAck;
    assign wbDat = state_q.wbDat;
    assign adcEnable = state_q.adcEnable;
    assign refEnable = state_q.refEnable;
    assign adcStart = state_q.adcStart;
    assign adcChanSel = state_q.adcChanSel;
    assign regulatorEnable = state_q.regulatorEnable;
    assign serialEnable = state_q.serialEnable;
    assign busAddr = state_q.busAddr;

endmodule

// ===== core/pmm_pkg.sv
package pmm_pkg;

    typedef enum logic [0:0] {
        PMM_IDLE,
        PMM_CONV
    } pmm_seq_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [31:0] dat;
        logic [3:0] sel;
    } pmm_wb_req_t;

    typedef struct packed {
        logic done;
        logic [11:0] data;
    } pmm_adc_res_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [3:0][23:0] res;
        logic [3:0][23:0] minv;
        logic [3:0][23:0] maxv;
        logic [3:0][23:0] thMax;
        logic [3:0][23:0] thMin;
    } pmm_regs_t;

    typedef struct packed {
        logic [7:0] pinsSync1;
        logic [7:0] pinsSync2;
        pmm_regs_t regs;
        pmm_seq_t seq;
        logic [1:0] step;
        logic [1:0] convChan;
        logic ssConv;
        logic [3:0] busAddr;
        logic serialEnable;
        logic adcEnable;
        logic refEnable;
        logic regulatorEnable;
        logic adcStart;
        logic [1:0] adcChanSel;
        logic wbAck;
        logic [31:0] wbDat;
    } pmm_state_t;

endpackage

// ===== test/pmm_adc_model.sv
`timescale 1ns/1ns
module pmm_adc_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic powered,
    input wire logic adcStart,
    input wire logic [1:0] adcChanSel,
    input wire logic [3:0][11:0] levels,
    input wire logic [7:0] lag,
    output pmm_pkg::pmm_adc_res_t adcRes
);
    import pmm_pkg::*;
    logic busy;
    logic [7:0] cnt;
    logic [1:0] chan;
    logic [11:0] lastData;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            cnt <= 8'h00;
            chan <= 2'h0;
            lastData <= 12'h000;
            adcRes <= '0;
        end else begin
            adcRes.done <= 1'b0;
            // Data lines do not hold the last result outside a strobe
            adcRes.data <= ~lastData;
            if (!powered) begin
                busy <= 1'b0;
            end else if (adcStart) begin
                busy <= 1'b1;
                cnt <= lag;
                chan <= adcChanSel;
            end else if (busy && cnt == 8'h00) begin
                busy <= 1'b0;
                adcRes.done <= 1'b1;
                adcRes.data <= levels[chan];
                lastData <= levels[chan];
            end else if (busy) begin
                cnt <= cnt - 8'h01;
            end
        end
    end
endmodule

// ===== test/pmm_monitor_asserts.sv
`timescale 1ns/1ns
module pmm_monitor_asserts (
    input wire logic core_clk,
    input wire logic rst,
    input wire pmm_pkg::pmm_wb_req_t wbReq,
    input wire logic wbAck,
    input wire logic [31:0] wbDat,
    input wire logic vddAboveUvlo,
    input wire logic lowSupplyAboveUvlo,
    input wire logic vddAboveLogicRst,
    input wire logic lowSupplyAboveLogicRst,
    input wire logic adcEnable,
    input wire logic refEnable,
    input wire logic adcStart,
    input wire logic regulatorEnable,
    input wire logic serialEnable
);
    import pmm_pkg::*;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);
    chk_ack_latency: assert property ($rose(wbReq.cyc && wbReq.stb) |=> wbAck)
        else $error("bus request not answered after one wait");
    chk_ack_single: assert property (wbAck |=> !wbAck)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property (wbAck |-> $past(wbReq.cyc && wbReq.stb))
        else $error("ack without request");
    chk_data_quiet: assert property (!wbAck |-> wbDat == 32'h0)
        else $error("read data outside ack");
    chk_reg_follows: assert property (regulatorEnable == refEnable)
        else $error("regulator enable differs from reference enable");
    chk_shdn_idle: assert property (!refEnable && !$past(refEnable) |-> !adcStart)
        else $error("conversion started in shutdown");
    chk_off_idle: assert property (!adcEnable && !$past(adcEnable) |-> !adcStart)
        else $error("conversion started while converter off");
    chk_start_single: assert property (adcStart |=> !adcStart)
        else $error("start longer than one cycle");
    chk_uvlo_up: assert property (
        (vddAboveUvlo || lowSupplyAboveUvlo) [*4] |=> serialEnable)
        else $error("serial logic not enabled");
    chk_uvlo_down: assert property (
        (!vddAboveUvlo && !lowSupplyAboveUvlo) [*4] |=> !adcEnable)
        else $error("converter still enabled");
    chk_logic_rst: assert property (
        (!vddAboveLogicRst && !lowSupplyAboveLogicRst) [*4] |=> !serialEnable)
        else $error("serial logic not reset");
endmodule

bind pmm_monitor pmm_monitor_asserts chk_u (
    .core_clk(core_clk), .rst(rst), .wbReq(wbReq), .wbAck(wbAck), .wbDat(wbDat),
    .vddAboveUvlo(vddAboveUvlo), .lowSupplyAboveUvlo(lowSupplyAboveUvlo),
    .vddAboveLogicRst(vddAboveLogicRst), .lowSupplyAboveLogicRst(lowSupplyAboveLogicRst),
    .adcEnable(adcEnable), .refEnable(refEnable), .adcStart(adcStart),
    .regulatorEnable(regulatorEnable), .serialEnable(serialEnable)
);

// ===== test/pmm_monitor_tb.sv
`timescale 1ns/1ns
module pmm_monitor_tb;
    import pmm_pkg::*;
    localparam logic [31:0] M12 = 32'h0000ffff;
    localparam logic [31:0] M24 = 32'h00ffffff;
    logic core_clk;
    logic rst;
    pmm_wb_req_t wbReq;
    logic wbAck;
    logic [31:0] wbDat;
    logic vddAboveUvlo, lowSupplyAboveUvlo, vddAboveLogicRst, lowSupplyAboveLogicRst;
    logic [1:0] pinHi, pinLo, adcChanSel;
    pmm_adc_res_t adcRes;
    logic adcEnable, refEnable, adcStart, regulatorEnable, serialEnable;
    logic [3:0] busAddr;
    logic [3:0][11:0] lvl;
    logic [7:0] lag;
    logic [31:0] rd;
    logic [7:0] srcCode [3] = '{8'h05, 8'h01, 8'h04};
    int srcCh [3] = '{2, 1, 3};
    int errTotal = 0;
    int checksDone = 0;

    initial core_clk = 1'b0;
    always #50 core_clk = ~core_clk;

    pmm_monitor dut_u (.core_clk(core_clk), .rst(rst), .wbReq(wbReq), .wbAck(wbAck),
        .wbDat(wbDat), .vddAboveUvlo(vddAboveUvlo), .lowSupplyAboveUvlo(lowSupplyAboveUvlo),
        .vddAboveLogicRst(vddAboveLogicRst), .lowSupplyAboveLogicRst(lowSupplyAboveLogicRst),
        .addr_select_pin_hi(pinHi), .addr_select_pin_lo(pinLo), .adcRes(adcRes),
        .adcEnable(adcEnable), .refEnable(refEnable), .adcStart(adcStart),
        .adcChanSel(adcChanSel), .regulatorEnable(regulatorEnable),
        .serialEnable(serialEnable), .busAddr(busAddr));
    pmm_adc_model adc_u (.core_clk(core_clk), .rst(rst), .powered(adcEnable && refEnable),
        .adcStart(adcStart), .adcChanSel(adcChanSel), .levels(lvl), .lag(lag), .adcRes(adcRes));

    task automatic fail(input string msg);
        errTotal++;
        $display("wrong value at %0t: %s", $time, msg);
    endtask

    // Waits for ack as long as it takes; only the watchdog ends a hang
    task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, dat: dat, sel: 4'hf};
        do begin
            @(posedge core_clk);
        end while (wbAck !== 1'b1);
        rd = wbDat;
        wbReq <= '0;
        @(posedge core_clk);
    endtask

    task automatic checkReg(input logic [7:0] adr, input logic [31:0] mask,
                            input logic [31:0] exp);
        wbXfer(1'b0, adr, 32'h0);
        checksDone++;
        if ((rd & mask) !== exp) fail($sformatf("reg %h read %h want %h", adr, rd & mask, exp));
    endtask

    task automatic checkPin(input logic [3:0] got, input logic [3:0] exp);
        checksDone++;
        if (got !== exp) fail($sformatf("pins %h want %h", got, exp));
    endtask

    task automatic wrapUp;
        if (errTotal == 0 && checksDone > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        wbReq = '0;
        {vddAboveUvlo, lowSupplyAboveUvlo, vddAboveLogicRst, lowSupplyAboveLogicRst} = 4'hf;
        pinHi = 2'h1;
        pinLo = 2'h2;
        lvl = {12'habc, 12'h456, 12'h789, 12'h123};
        lag = 8'd40;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        checkReg(8'h00, 32'hff, 32'h05);
        checkReg(8'h2c, M24, M24);
        checkReg(8'h4c, M24, M24);
        checkReg(8'h5c, M24, 32'h0);
        lag <= 8'd3;
        repeat (100) @(posedge core_clk);
        checkReg(8'h10, M12, 32'h1230);
        checkReg(8'h14, M12, 32'h4560);
        checkReg(8'h18, M12, 32'habc0);
        checkReg(8'h1c, M24, 32'(lvl[0]) * 32'(lvl[2]));
        lvl[0] <= 12'h050;
        repeat (60) @(posedge core_clk);
        lvl[0] <= 12'h800;
        repeat (60) @(posedge core_clk);
        checkReg(8'h20, M12, 32'h0500);
        checkReg(8'h30, M12, 32'h8000);
        for (int i = 0; i < 3; i++) begin
            wbXfer(1'b1, 8'h00, {24'h0, srcCode[i]});
            repeat (60) @(posedge core_clk);
            checkReg(8'h1c, M24, 32'(lvl[0]) * 32'(lvl[srcCh[i]]));
        end
        checkReg(8'h3c, M24, 32'h800 * 32'habc);
        wbXfer(1'b1, 8'h00, 32'h07);
        lvl[0] <= 12'h321;
        pinHi <= 2'h3;
        pinLo <= 2'h0;
        repeat (60) @(posedge core_clk);
        checkPin({2'b0, regulatorEnable, refEnable}, 4'h0);
        checkPin(busAddr, 4'h6);
        checkReg(8'h04, 32'hff, 32'h61);
        checkReg(8'h10, M12, 32'h8000);
        wbXfer(1'b1, 8'h4c, 32'h123456);
        checkReg(8'h4c, M24, 32'h123456);
        wbXfer(1'b1, 8'h00, 32'h05);
        repeat (60) @(posedge core_clk);
        checkReg(8'h10, M12, 32'h3210);
        checkReg(8'h4c, M24, 32'h123456);
        checkPin({2'b0, regulatorEnable, refEnable}, 4'h3);
        checkPin(busAddr, 4'hc);
        lvl[3] <= 12'h0aa;
        lag <= 8'd20;
        wbXfer(1'b1, 8'h00, 32'he5);
        checkReg(8'h00, 32'h08, 32'h08);
        repeat (100) @(posedge core_clk);
        checkReg(8'h00, 32'h08, 32'h00);
        checkPin({2'b0, adcChanSel}, 4'h3);
        checkReg(8'h18, M12, 32'h0aa0);
        checkReg(8'h28, M12, 32'h0aa0);
        wbXfer(1'b1, 8'h10, 32'hfff0);
        checkReg(8'h30, M12, 32'hfff0);
        wbXfer(1'b1, 8'h10, 32'h0010);
        checkReg(8'h20, M12, 32'h0010);
        wbXfer(1'b1, 8'h20, 32'hffffffff);
        wbXfer(1'b1, 8'h30, 32'h0);
        lvl[0] <= 12'h200;
        wbXfer(1'b1, 8'h00, 32'h85);
        repeat (100) @(posedge core_clk);
        checkReg(8'h20, M12, 32'h2000);
        checkReg(8'h30, M12, 32'h2000);
        checkReg(8'h1c, M24, 32'h321 * 32'h456);
        wbXfer(1'b1, 8'h60, 32'hdead);
        checkReg(8'h60, 32'hffffffff, 32'h0);
        vddAboveUvlo <= 1'b0;
        repeat (10) @(posedge core_clk);
        checkPin({3'b0, adcEnable}, 4'h1);
        lowSupplyAboveUvlo <= 1'b0;
        repeat (10) @(posedge core_clk);
        checkPin({3'b0, adcEnable}, 4'h0);
        lowSupplyAboveUvlo <= 1'b1;
        repeat (10) @(posedge core_clk);
        checkPin({3'b0, adcEnable}, 4'h1);
        {vddAboveUvlo, lowSupplyAboveUvlo, vddAboveLogicRst, lowSupplyAboveLogicRst} <= 4'h0;
        repeat (10) @(posedge core_clk);
        checkPin({3'b0, serialEnable}, 4'h0);
        {vddAboveUvlo, lowSupplyAboveUvlo, vddAboveLogicRst, lowSupplyAboveLogicRst} <= 4'hf;
        repeat (10) @(posedge core_clk);
        checkPin({3'b0, serialEnable}, 4'h1);
        checkReg(8'h00, 32'hff, 32'h05);
        wrapUp;
    end

    // Whole run needs about 900 cycles
    initial begin
        repeat (6000) @(posedge core_clk);
        errTotal++;
        wrapUp;
    end
endmodule
